// ==== dv/strap_config_latch_assertions.sv ====
// port-level checks for the strap configuration latch
`timescale 1ns/1ns
`default_nettype none
module strap_config_latch_assertions (
   input wire logic       clk,
   input wire logic       sys_rst,
   input wire logic       receive_data_bit3_pin,
   input wire logic       receive_data_bit0_pin,
   input wire logic       receive_error_pin,
   input wire logic       general_purpose_one_pin,
   input wire logic       led_two_pin,
   input wire logic       led_zero_pin,
   input wire logic       receive_data_bit1_pin,
   input wire logic       receive_data_bit2_pin,
   input wire logic       rx_valid_pin_strap,
   input wire logic       general_purpose_two_pin,
   input wire logic       s_axi_bvalid,
   input wire logic [3:0] mgmt_addr,
   input wire logic       tx_amp_high,
   input wire logic [1:0] mac_mode,
   input wire logic       rx_valid_pure,
   input wire logic       led_one_output_sel,
   input wire logic       term_below_40,
   input wire logic       mgmt_ready
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // strap pins are held steady by the bench until the latch reports ready
   sequence s_up; $rose(mgmt_ready); endsequence
   property p_addr; s_up |-> mgmt_addr == {receive_data_bit3_pin, receive_data_bit0_pin,
      receive_error_pin, general_purpose_one_pin}; endproperty
   a_addr: assert property (p_addr) else $error("address decode wrong");
   property p_zero; !(receive_data_bit3_pin | receive_data_bit0_pin | receive_error_pin |
      general_purpose_one_pin) && $rose(mgmt_ready) |-> mgmt_addr == 4'h0; endproperty
   a_zero: assert property (p_zero) else $error("default address not zero");
   property p_reach; s_up |-> tx_amp_high == led_two_pin; endproperty
   a_reach: assert property (p_reach) else $error("amplitude decode wrong");
   property p_mac; s_up |-> mac_mode == {led_zero_pin, receive_data_bit1_pin}; endproperty
   a_mac: assert property (p_mac) else $error("interface mode wrong");
   property p_rxv; s_up |-> rx_valid_pure == receive_data_bit2_pin; endproperty
   a_rxv: assert property (p_rxv) else $error("receive-valid select wrong");
   property p_clk; s_up |-> led_one_output_sel == rx_valid_pin_strap; endproperty
   a_clk: assert property (p_clk) else $error("clock pin select wrong");
   property p_term; s_up |-> (term_below_40 == general_purpose_two_pin) [*2]; endproperty
   a_term: assert property (p_term) else $error("termination select wrong");
   property p_ready; $fell(sys_rst) |-> ##[1:5] mgmt_ready; endproperty
   a_ready: assert property (p_ready) else $error("ready late");
   property p_rst; disable iff (1'b0) sys_rst |=> !mgmt_ready && mgmt_addr == 4'h0;
   endproperty
   a_rst: assert property (p_rst) else $error("reset not clearing");
   // only a register write may move latched settings
   property p_hold; mgmt_ready && $past(mgmt_ready) && !s_axi_bvalid && !$past(s_axi_bvalid)
      && !$past(s_axi_bvalid, 2) |-> $stable(mgmt_addr) && $stable(mac_mode); endproperty
   a_hold: assert property (p_hold) else $error("setting moved");
   c_resv: cover property ($rose(mgmt_ready) && mac_mode == 2'b10);
   c_led: cover property ($rose(mgmt_ready) && led_one_output_sel);
   c_wr: cover property (mgmt_ready && s_axi_bvalid);
endmodule
`default_nettype wire

// ==== dv/strap_pull_model.sv ====
// board strap resistors: each strap pin pulled to the level of its pull_sel bit
`timescale 1ns/1ns
`default_nettype none
module strap_pull_model (
   input  wire logic [9:0] pull_sel,
   output logic            receive_data_bit3_pin,
   output logic            receive_data_bit0_pin,
   output logic            receive_error_pin,
   output logic            general_purpose_one_pin,
   output logic            led_two_pin,
   output logic            led_zero_pin,
   output logic            receive_data_bit1_pin,
   output logic            receive_data_bit2_pin,
   output logic            rx_valid_pin_strap,
   output logic            general_purpose_two_pin
);
   // every pin, termination included, is pulled hard; none is left floating
   assign {general_purpose_two_pin, rx_valid_pin_strap, receive_data_bit2_pin, led_zero_pin,
      receive_data_bit1_pin, led_two_pin, receive_data_bit3_pin, receive_data_bit0_pin,
      receive_error_pin, general_purpose_one_pin} = pull_sel;
endmodule
`default_nettype wire

// ==== dv/tb_top.sv ====
// self-checking bench for the strap configuration latch
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import strap_cfg_pkg::*;
   logic             clk, sys_rst, link_forced_mode;
   logic [9:0]       pull_sel, v;
   logic [7:0]       s_axi_awaddr, s_axi_araddr;
   logic [31:0]      s_axi_wdata;
   logic             s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic [1:0]       r;
   logic [33:0]      exp_q[$];
   int               err_total, n_compared;
   wire logic        receive_data_bit3_pin, receive_data_bit0_pin, receive_error_pin,
      general_purpose_one_pin, led_two_pin, led_zero_pin, receive_data_bit1_pin,
      receive_data_bit2_pin, rx_valid_pin_strap, general_purpose_two_pin;
   wire logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire logic [1:0]  s_axi_bresp, s_axi_rresp, mac_mode;
   wire logic [31:0] s_axi_rdata;
   wire logic [3:0]  mgmt_addr;
   wire logic        tx_amp_high, rx_valid_pure, led_one_output_sel, term_below_40, mgmt_ready;
   // query address and expected group, unmapped neighbours included
   logic [23:0]      mmd_tab [16] = '{24'h10_0001, 24'h18_F801, 24'h18_F900, 24'h30_0003,
      24'h38_E703, 24'h38_E800, 24'h02_0007, 24'h02_0F07, 24'h02_1000, 24'h01_301F,
      24'h01_3100, 24'h03_001F, 24'h0E_011F, 24'h0E_0200, 24'h00_001F, 24'h20_0000};

   strap_pull_model board (.pull_sel, .receive_data_bit3_pin, .receive_data_bit0_pin,
      .receive_error_pin, .general_purpose_one_pin, .led_two_pin, .led_zero_pin,
      .receive_data_bit1_pin, .receive_data_bit2_pin, .rx_valid_pin_strap,
      .general_purpose_two_pin);
   strap_config_latch uut (.clk, .sys_rst, .receive_data_bit3_pin, .receive_data_bit0_pin,
      .receive_error_pin, .general_purpose_one_pin, .led_two_pin, .led_zero_pin,
      .receive_data_bit1_pin, .receive_data_bit2_pin, .rx_valid_pin_strap,
      .general_purpose_two_pin, .link_forced_mode, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mgmt_addr,
      .tx_amp_high, .mac_mode, .rx_valid_pure, .led_one_output_sel, .term_below_40,
      .mgmt_ready);

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic chk(input logic [33:0] seen, input logic [33:0] want);
      n_compared++;
      if (seen !== want) begin
         err_total++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask

   task automatic report_and_stop();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic hung();
      err_total++;
      report_and_stop();
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rsp);
      int n;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 64; n++) begin
         @(posedge clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      s_axi_bready <= 1'b0;
      rsp = s_axi_bresp;
      if (n == 64) hung();
   endtask

   task automatic rd(input logic [7:0] a, input logic [33:0] want);
      int n;
      @(posedge clk);
      exp_q.push_back(want);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 64; n++) begin
         @(posedge clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      s_axi_rready <= 1'b0;
      if (n == 64) hung();
   endtask

   // pins change with reset raised, so they settle well before release
   task automatic hard_reset(input logic [9:0] s);
      int n;
      pull_sel <= s;
      sys_rst <= 1'b1;
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      for (n = 0; n < 20 && !mgmt_ready; n++) @(posedge clk);
      if (n == 20) hung();
   endtask

   always @(posedge clk) begin
      if (s_axi_rvalid && s_axi_rready) begin
         chk({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
      end
   end

   initial begin
      {sys_rst, link_forced_mode, pull_sel, s_axi_awaddr, s_axi_araddr} = 28'h800_0000;
      {s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 35'h0;
      {s_axi_arvalid, s_axi_rready, err_total, n_compared} = 66'h0;
      v = 10'($urandom(32'h6cc8fa39));
      for (int k = 0; k < 5; k++) begin
         v = (k == 0) ? 10'h000 : 10'($urandom());
         if (k > 0) v[6:5] = 2'(k - 1);
         @(posedge clk);
         link_forced_mode <= k[0];
         hard_reset(v);
         rd(ADDR_STATUS, {22'h0, v[6:5] == MAC_RESERVED, k[0], v});
         rd(ADDR_AN_ADV, {21'h0, v[4], 12'h0});
         rd(ADDR_FORCE_AMP, {21'h0, v[4] & k[0], 12'h0});
      end
      wr(ADDR_CONTROL, 32'h0000_0002, r);
      rd(ADDR_FORCE_AMP, {21'h0, v[4], 12'h0});
      for (int i = 0; i < 16; i++) begin
         wr(ADDR_MMD_QUERY, {16'h0, mmd_tab[i][23:8]}, r);
         rd(ADDR_MMD_RESULT, {26'h0, mmd_tab[i][7:0]});
      end
      wr(ADDR_OVERRIDE, {12'h0, ~v[3:0], 6'h0, 10'h00F}, r);
      repeat (3) @(posedge clk);
      chk({30'h0, mgmt_addr}, {30'h0, ~v[3:0]});
      pull_sel <= ~v;
      wr(ADDR_CONTROL, 32'h0000_0001, r);
      repeat (3) @(posedge clk);
      chk({30'h0, mgmt_addr}, {30'h0, v[3:0]});
      rd(ADDR_CONTROL, 34'h0);
      wr(8'h40, 32'h0000_0001, r);
      chk({32'h0, r}, {32'h0, RESP_SLVERR});
      rd(8'h44, {RESP_SLVERR, 32'h0});
      repeat (4) @(posedge clk);
      report_and_stop();
   end
endmodule

bind strap_config_latch strap_config_latch_assertions chk_i (.clk, .sys_rst,
   .receive_data_bit3_pin, .receive_data_bit0_pin, .receive_error_pin,
   .general_purpose_one_pin, .led_two_pin, .led_zero_pin, .receive_data_bit1_pin,
   .receive_data_bit2_pin, .rx_valid_pin_strap, .general_purpose_two_pin, .s_axi_bvalid,
   .mgmt_addr, .tx_amp_high, .mac_mode, .rx_valid_pure, .led_one_output_sel,
   .term_below_40, .mgmt_ready);
`default_nettype wire

// ==== logic/strap_cfg_pkg.sv ====
// constants for the strap configuration latch and its register map
package strap_cfg_pkg;
   // register byte addresses
   localparam logic [7:0] ADDR_STATUS    = 8'h00;
   localparam logic [7:0] ADDR_CONTROL   = 8'h04;
   localparam logic [7:0] ADDR_AN_ADV    = 8'h08;
   localparam logic [7:0] ADDR_FORCE_AMP = 8'h0C;
   localparam logic [7:0] ADDR_MMD_QUERY = 8'h10;
   localparam logic [7:0] ADDR_MMD_RESULT = 8'h14;
   localparam logic [7:0] ADDR_OVERRIDE  = 8'h18;

   // documented device register addresses mirrored by the above
   localparam logic [15:0] DEV_AN_ADV_ADDR    = 16'h020E;
   localparam logic [15:0] DEV_FORCE_AMP_ADDR = 16'h18F6;
   localparam int          REACH_BIT          = 12;

   // status word fields
   localparam int ST_ADDR_LSB   = 0;
   localparam int ST_REACH_BIT  = 4;
   localparam int ST_MAC_LSB    = 5;
   localparam int ST_RXV_BIT    = 7;
   localparam int ST_CLK_BIT    = 8;
   localparam int ST_TERM_BIT   = 9;
   localparam int ST_FORCE_BIT  = 10;
   localparam int ST_RESV_BIT   = 11;

   // control word fields
   localparam int CT_SWRST_BIT  = 0;
   localparam int CT_FORCE_BIT  = 1;

   // override enables (bit n) and values (bit n+16); field order as status
   localparam int OV_VAL_LSB    = 16;
   localparam int OV_WIDTH      = 10;

   localparam logic [1:0] MAC_MII         = 2'b00;
   localparam logic [1:0] MAC_RMII_MASTER = 2'b01;
   localparam logic [1:0] MAC_RESERVED    = 2'b10;
   localparam logic [1:0] MAC_RMII_SLAVE  = 2'b11;

   localparam logic [4:0] MMD_NONE = 5'h00;
   localparam logic [4:0] MMD_PMA  = 5'h01;
   localparam logic [4:0] MMD_PCS  = 5'h03;
   localparam logic [4:0] MMD_AN   = 5'h07;
   localparam logic [4:0] MMD_VEND = 5'h1F;

   localparam logic [15:0] R1_LO = 16'h1000;
   localparam logic [15:0] R1_HI = 16'h18F8;
   localparam logic [15:0] R3_LO = 16'h3000;
   localparam logic [15:0] R3_HI = 16'h38E7;
   localparam logic [15:0] R7_LO = 16'h0200;
   localparam logic [15:0] R7_HI = 16'h020F;
   localparam logic [15:0] RV_LO = 16'h0000;
   localparam logic [15:0] RV_HI = 16'h0130;
   localparam logic [15:0] RW_LO = 16'h0300;
   localparam logic [15:0] RW_HI = 16'h0E01;

   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // last settle count before the straps are caught; covers both sync stages
   localparam logic [1:0] SETTLE_LAST = 2'b01;

   typedef enum logic [1:0] {LD_SAMPLE, LD_RUN} load_state_t;
endpackage

// ==== logic/strap_config_latch.sv ====
// strap sampling, decode and AXI4-Lite register access for the PHY setup
//
// The address map and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module strap_config_latch
   import strap_cfg_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        receive_data_bit3_pin,
   input  wire logic        receive_data_bit0_pin,
   input  wire logic        receive_error_pin,
   input  wire logic        general_purpose_one_pin,
   input  wire logic        led_two_pin,
   input  wire logic        led_zero_pin,
   input  wire logic        receive_data_bit1_pin,
   input  wire logic        receive_data_bit2_pin,
   input  wire logic        rx_valid_pin_strap,
   input  wire logic        general_purpose_two_pin,
   input  wire logic        link_forced_mode,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic [3:0]       mgmt_addr,
   output logic             tx_amp_high,
   output logic [1:0]       mac_mode,
   output logic             rx_valid_pure,
   output logic             led_one_output_sel,
   output logic             term_below_40,
   output logic             mgmt_ready
);

   // strap order in the raw word: addr[3:0], reach, mac[1:0], rxv, clk, term
   localparam int NSTRAP = OV_WIDTH;

   // group lookup for a register address; unmapped gives zero
   function automatic logic [4:0] mmd_of(input logic [15:0] a);
      if (a >= R1_LO && a <= R1_HI) begin
         mmd_of = MMD_PMA;
      end else if (a >= R3_LO && a <= R3_HI) begin
         mmd_of = MMD_PCS;
      end else if (a >= R7_LO && a <= R7_HI) begin
         mmd_of = MMD_AN;
      end else if ((a >= RV_LO && a <= RV_HI) || (a >= RW_LO && a <= RW_HI)) begin
         mmd_of = MMD_VEND;
      end else begin
         mmd_of = MMD_NONE;
      end
   endfunction

   // every mapped word answers OKAY; read-only words simply ignore writes
   function automatic logic addr_known(input logic [7:0] a);
      if (a == ADDR_STATUS || a == ADDR_CONTROL || a == ADDR_AN_ADV) begin
         addr_known = 1'b1;
      end else if (a == ADDR_FORCE_AMP || a == ADDR_MMD_QUERY) begin
         addr_known = 1'b1;
      end else if (a == ADDR_MMD_RESULT || a == ADDR_OVERRIDE) begin
         addr_known = 1'b1;
      end else begin
         addr_known = 1'b0;
      end
   endfunction

   // pins are slow board levels; two stages before anything reads them
   logic [NSTRAP-1:0] pin_raw;
   logic [NSTRAP-1:0] pin_s1_r;
   logic [NSTRAP-1:0] pin_s2_r;
   assign pin_raw = {general_purpose_two_pin, rx_valid_pin_strap, receive_data_bit2_pin,
                     led_zero_pin, receive_data_bit1_pin, led_two_pin,
                     receive_data_bit3_pin, receive_data_bit0_pin, receive_error_pin,
                     general_purpose_one_pin};

   always_ff @(posedge clk) begin
      pin_s1_r <= pin_raw;
      pin_s2_r <= pin_s1_r;
   end

   // sampling waits two cycles after reset so the synchroniser holds real pin data
   load_state_t       ld_r;
   logic [1:0]        settle_r;
   logic [NSTRAP-1:0] strap_r;
   logic [NSTRAP-1:0] ov_en_r;
   logic [NSTRAP-1:0] ov_val_r;
   logic              force_r;
   logic              swrst;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ld_r     <= LD_SAMPLE;
         settle_r <= 2'b00;
      end else if (ld_r == LD_SAMPLE) begin
         settle_r <= settle_r + 2'b01;
         if (settle_r == SETTLE_LAST) begin
            ld_r <= LD_RUN;
         end
      end
   end

   // straps are caught once after hard reset; soft reset never resamples
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         strap_r <= '0;
      end else if (ld_r == LD_SAMPLE && settle_r == SETTLE_LAST) begin
         strap_r <= pin_s2_r;
      end
   end

   // effective word; soft reset drops overrides so the latched straps apply again
   logic [NSTRAP-1:0] eff;
   assign eff = (strap_r & ~ov_en_r) | (ov_val_r & ov_en_r);

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         mgmt_addr          <= '0;
         tx_amp_high        <= 1'b0;
         mac_mode           <= MAC_MII;
         rx_valid_pure      <= 1'b0;
         led_one_output_sel <= 1'b0;
         term_below_40      <= 1'b0;
      end else begin
         mgmt_addr          <= eff[ST_ADDR_LSB+3:ST_ADDR_LSB];
         tx_amp_high        <= eff[ST_REACH_BIT];
         mac_mode           <= eff[ST_MAC_LSB+1:ST_MAC_LSB];
         rx_valid_pure      <= eff[ST_RXV_BIT];
         led_one_output_sel <= eff[ST_CLK_BIT];
         term_below_40      <= eff[ST_TERM_BIT];
      end
   end

   // ready trails the latch by a cycle so the first access sees final settings
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         mgmt_ready <= 1'b0;
      end else begin
         mgmt_ready <= (ld_r == LD_RUN);
      end
   end

   // a forced link comes from the pin or from the control bit
   logic force_eff;
   assign force_eff = force_r | link_forced_mode;

   // write channel: address and data taken in either order
   logic        aw_have_r;
   logic        w_have_r;
   logic [7:0]  aw_addr_r;
   logic [31:0] w_data_r;
   logic [3:0]  w_strb_r;
   logic        do_write;
   logic [15:0] mmd_q_r;

   assign do_write = aw_have_r && w_have_r && !s_axi_bvalid;
   // soft reset is a one-cycle pulse decoded from the control write itself
   assign swrst = do_write && aw_addr_r == ADDR_CONTROL && w_strb_r[0]
                  && w_data_r[CT_SWRST_BIT];

   // address half of a write, parked until its data partner arrives
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         aw_have_r     <= 1'b0;
         aw_addr_r     <= '0;
         s_axi_awready <= 1'b0;
      end else begin
         s_axi_awready <= !aw_have_r && !(s_axi_awvalid && s_axi_awready);
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end
         if (do_write) begin
            aw_have_r <= 1'b0;
         end
      end
   end

   // data half of a write; ready stays low while a word is parked
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         w_have_r     <= 1'b0;
         w_data_r     <= '0;
         w_strb_r     <= '0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_wready <= !w_have_r && !(s_axi_wvalid && s_axi_wready);
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
         if (do_write) begin
            w_have_r <= 1'b0;
         end
      end
   end

   // response; a new write waits in do_write until this one is taken
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= addr_known(aw_addr_r) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // control register; soft reset also drops the forced-link request
   always_ff @(posedge clk) begin
      if (sys_rst || swrst) begin
         force_r <= 1'b0;
      end else if (do_write && aw_addr_r == ADDR_CONTROL && w_strb_r[0]) begin
         force_r <= w_data_r[CT_FORCE_BIT];
      end
   end

   // overrides; clearing them on soft reset puts the latched straps back in charge
   always_ff @(posedge clk) begin
      if (sys_rst || swrst) begin
         ov_en_r  <= '0;
         ov_val_r <= '0;
      end else if (do_write && aw_addr_r == ADDR_OVERRIDE) begin
         if (w_strb_r[0]) begin
            ov_en_r[7:0] <= w_data_r[7:0];
         end
         if (w_strb_r[1]) begin
            ov_en_r[NSTRAP-1:8] <= w_data_r[NSTRAP-1:8];
         end
         if (w_strb_r[2]) begin
            ov_val_r[7:0] <= w_data_r[OV_VAL_LSB+7:OV_VAL_LSB];
         end
         if (w_strb_r[3]) begin
            ov_val_r[NSTRAP-1:8] <= w_data_r[OV_VAL_LSB+NSTRAP-1:OV_VAL_LSB+8];
         end
      end
   end

   // query word for the group lookup; the result is read back combinationally
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         mmd_q_r <= '0;
      end else if (do_write && aw_addr_r == ADDR_MMD_QUERY) begin
         if (w_strb_r[0]) begin
            mmd_q_r[7:0] <= w_data_r[7:0];
         end
         if (w_strb_r[1]) begin
            mmd_q_r[15:8] <= w_data_r[15:8];
         end
      end
   end

   // read channel: one read at a time, answer one cycle after the address
   logic [31:0] rd_word;
   logic [31:0] reach_word;
   // both mirror words carry the reach bit at the same position
   always_comb begin
      reach_word = '0;
      reach_word[REACH_BIT] = eff[4];
   end

   always_comb begin
      rd_word = '0;
      if (s_axi_araddr == ADDR_STATUS) begin
         rd_word[ST_ADDR_LSB+3:ST_ADDR_LSB] = eff[3:0];
         rd_word[ST_REACH_BIT]              = eff[4];
         rd_word[ST_MAC_LSB+1:ST_MAC_LSB]   = eff[6:5];
         rd_word[ST_RXV_BIT]                = eff[7];
         rd_word[ST_CLK_BIT]                = eff[8];
         rd_word[ST_TERM_BIT]               = eff[9];
         rd_word[ST_FORCE_BIT]              = force_eff;
         rd_word[ST_RESV_BIT]               = (eff[6:5] == MAC_RESERVED);
      end else if (s_axi_araddr == ADDR_CONTROL) begin
         rd_word[CT_FORCE_BIT] = force_r;
      end else if (s_axi_araddr == ADDR_AN_ADV) begin
         rd_word = reach_word;
      end else if (s_axi_araddr == ADDR_FORCE_AMP) begin
         rd_word = force_eff ? reach_word : '0;
      end else if (s_axi_araddr == ADDR_MMD_QUERY) begin
         rd_word[15:0] = mmd_q_r;
      end else if (s_axi_araddr == ADDR_MMD_RESULT) begin
         rd_word[4:0] = mmd_of(mmd_q_r);
      end else if (s_axi_araddr == ADDR_OVERRIDE) begin
         rd_word[NSTRAP-1:0]                   = ov_en_r;
         rd_word[OV_VAL_LSB+NSTRAP-1:OV_VAL_LSB] = ov_val_r;
      end
   end

   logic rd_ok;
   assign rd_ok = addr_known(s_axi_araddr);

   // address side of a read; closed while an answer is outstanding
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s_axi_arready <= 1'b0;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      end
   end

   // read answer, captured at the address handshake and held until taken
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
         s_axi_rresp  <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_word;
         s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule
`default_nettype wire
